// File: rtl/iphy_pkg.sv
// package for the indirect phy register access engine
package iphy_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned PHY_DATA_W = 16;

  // register byte offsets
  localparam logic [11:0] OFF_ACCESS_DATA = 12'h0_0a4;
  localparam logic [11:0] OFF_ACCESS_CTRL = 12'h0_0a8;

  // access control field positions
  localparam int unsigned CTRL_ADDR_LSB  = 11;
  localparam int unsigned CTRL_INDEX_LSB = 6;
  localparam int unsigned CTRL_WNR_BIT   = 1;
  localparam int unsigned CTRL_BUSY_BIT  = 0;

  // reset values
  localparam logic [4:0]  RST_PHY_ADDR  = 5'h00;
  localparam logic [4:0]  RST_PHY_INDEX = 5'h00;
  localparam logic        RST_WNR       = 1'b0;
  localparam logic [15:0] RST_DATA      = 16'h0000;

  // management cycle timing: mdc divider and frame length
  localparam int unsigned MDC_DIV     = 10;
  localparam int unsigned FRAME_BITS  = 64;

  typedef struct packed {
    logic        wnr;
    logic [4:0]  phy_addr;
    logic [4:0]  reg_index;
    logic [15:0] wdata;
  } iphy_req_s;

  typedef struct packed {
    logic        done;
    logic [15:0] rdata;
  } iphy_rsp_s;

endpackage

// File: rtl/iphy_mgmt_engine.sv
// clause 22 management frame engine toward the internal phys
`timescale 1ns/10ps
module iphy_mgmt_engine #(
  parameter int unsigned DIV = 10
) (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              start_i,
  input  iphy_pkg::iphy_req_s    req_i,
  output iphy_pkg::iphy_rsp_s    rsp_o,
  output logic                   mdc_o,
  output logic                   mdio_o,
  output logic                   mdio_oe_o,
  input  wire logic              mdio_i
);
  import iphy_pkg::*;

  // half period must outlast the two-flop input synchroniser
  if (DIV < 3 || DIV > 256) begin : g_bad_div
    $error("DIV must be between 3 and 256");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} iphy_eng_e;

  iphy_eng_e   state_q;
  logic [7:0]  div_q;
  logic        tick;
  logic [6:0]  bit_q;
  logic [63:0] shift_q;
  logic [15:0] rd_q;
  logic        mdc_q;
  logic        in_s1_q;
  logic        in_s2_q;

  assign tick = (div_q == 8'(DIV - 1));

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || state_q != ST_RUN || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      in_s1_q <= 1'b0;
      in_s2_q <= 1'b0;
    end else begin
      in_s1_q <= mdio_i;
      in_s2_q <= in_s1_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
      bit_q   <= 7'h00;
      shift_q <= 64'h0000_0000_0000_0000;
      rd_q    <= 16'h0000;
      mdc_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          mdc_q <= 1'b0;
          if (start_i) begin
            // preamble, start, opcode, address, index, turnaround, data
            shift_q <= {32'hffff_ffff, 2'b01, req_i.wnr ? 2'b01 : 2'b10,
                        req_i.phy_addr, req_i.reg_index, 2'b10, req_i.wdata};
            bit_q   <= 7'h00;
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (tick) begin
            mdc_q <= ~mdc_q;
            if (mdc_q) begin
              shift_q <= {shift_q[62:0], 1'b0};
              bit_q   <= bit_q + 7'h01;
              if (bit_q >= 7'd48) begin
                rd_q <= {rd_q[14:0], in_s2_q};
              end
              if (bit_q == 7'(FRAME_BITS - 1)) begin
                state_q <= ST_DONE;
              end
            end
          end
        end
        ST_DONE: begin
          mdc_q   <= 1'b0;
          state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign mdc_o      = mdc_q;
  assign mdio_o     = shift_q[63];
  assign mdio_oe_o  = (state_q == ST_RUN) && (req_i.wnr || bit_q < 7'd46);
  assign rsp_o.done  = (state_q == ST_DONE);
  assign rsp_o.rdata = rd_q;

endmodule

// File: rtl/iphy_access.sv
// indirect phy register access: control and data registers over a plain port
// Notes on behaviour
// R1 - each write of the control register starts one management cycle; a write made while a cycle runs starts none
// R2 - phy address at control bits 15:11, read/write, resets to zero
// R3 - register index at control bits 10:6, read/write, resets to zero
// R4 - direction bit 1: one writes data register to phy, zero reads
// R5 - busy bit 0 read only, set on control write, held during access
// R6 - busy clears itself once the phy access has finished
// R7 - software polls busy clear before writing data or control
// R8 - software keeps data unchanged during a write until busy clears
// R9 - read data loaded into data register before busy clears
// R10 - only real phys reachable, virtual phy never addressed here
// R11 - data bits 15:0; read shows phy data or last software write
// R12 - after reset busy is zero and no cycle runs
// R13 - control bits 31:16 and 5:2 read zero, writes ignored
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
module iphy_access #(
  parameter int unsigned MDC_DIV = iphy_pkg::MDC_DIV
) (
  input  wire logic                          CLK_I,
  input  wire logic                          RST_B_I,
  input  wire logic [iphy_pkg::ADDR_W-1:0]   ADDR_I,
  input  wire logic [iphy_pkg::DATA_W-1:0]   WDATA_I,
  input  wire logic                          WR_I,
  input  wire logic                          RD_I,
  output logic      [iphy_pkg::DATA_W-1:0]   RDATA_O,
  output logic                               MDC_O,
  output logic                               MDIO_O,
  output logic                               MDIO_OE_O,
  input  wire logic                          MDIO_I
);
  import iphy_pkg::*;

  // read sampling needs a half period longer than the synchroniser
  if (MDC_DIV < 3 || MDC_DIV > 255) begin : g_bad_div
    $error("MDC_DIV out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  logic [4:0]  phy_addr_q;
  logic [4:0]  reg_index_q;
  logic        wnr_q;
  logic        busy_q;
  logic [15:0] sw_data_q;
  logic [15:0] phy_data_q;
  logic        start_q;
  logic [31:0] rdata_q;
  logic        wr_ctrl;
  logic        wr_data;
  iphy_req_s   req;
  iphy_rsp_s   rsp;

  assign wr_ctrl = WR_I && (ADDR_I == OFF_ACCESS_CTRL);
  assign wr_data = WR_I && (ADDR_I == OFF_ACCESS_DATA);

  // R2 R3 R4 control fields
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      phy_addr_q  <= RST_PHY_ADDR;
      reg_index_q <= RST_PHY_INDEX;
      wnr_q       <= RST_WNR;
    end else if (wr_ctrl) begin
      phy_addr_q  <= WDATA_I[CTRL_ADDR_LSB +: 5];
      reg_index_q <= WDATA_I[CTRL_INDEX_LSB +: 5];
      wnr_q       <= WDATA_I[CTRL_WNR_BIT];
    end
  end

  // R1 start pulse
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      start_q <= 1'b0;
    end else begin
      start_q <= wr_ctrl;
    end
  end

  // R5 R6 R12 busy flag
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      busy_q <= 1'b0;
    end else if (wr_ctrl) begin
      busy_q <= 1'b1;
    end else if (rsp.done && !start_q) begin
      busy_q <= 1'b0;
    end
  end

  // R11 software data
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      sw_data_q <= RST_DATA;
    end else if (wr_data) begin
      sw_data_q <= WDATA_I[15:0];
    end
  end

  // R9 load returned data
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      phy_data_q <= RST_DATA;
    end else if (rsp.done && !wnr_q) begin
      phy_data_q <= rsp.rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port

  // R11 R13 read mux
  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      rdata_q <= 32'h0000_0000;
    end else if (RD_I && ADDR_I == OFF_ACCESS_CTRL) begin
      rdata_q <= {16'h0000, phy_addr_q, reg_index_q, 4'h0, wnr_q, busy_q};
    end else if (RD_I && ADDR_I == OFF_ACCESS_DATA) begin
      rdata_q <= {16'h0000, wnr_q ? sw_data_q : phy_data_q};
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign RDATA_O = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // engine

  // R10 physical phy bus only
  assign req.wnr       = wnr_q;
  assign req.phy_addr  = phy_addr_q;
  assign req.reg_index = reg_index_q;
  assign req.wdata     = sw_data_q;

  iphy_mgmt_engine #(
    .DIV (MDC_DIV)
  ) u_engine (
    .clk_i     (CLK_I),
    .rst_b_i   (RST_B_I),
    .start_i   (start_q),
    .req_i     (req),
    .rsp_o     (rsp),
    .mdc_o     (MDC_O),
    .mdio_o    (MDIO_O),
    .mdio_oe_o (MDIO_OE_O),
    .mdio_i    (MDIO_I)
  );

endmodule

// File: dv/iphy_access_sva.sv
// assertions for the indirect phy access block
`timescale 1ns/10ps
module iphy_access_sva
  import iphy_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        RST_B_I,
  input wire logic [11:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic        MDC_O,
  input wire logic        MDIO_OE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  logic cw, cr, dr, ur;
  assign cw = WR_I && ADDR_I == OFF_ACCESS_CTRL;
  assign cr = RD_I && ADDR_I == OFF_ACCESS_CTRL;
  assign dr = RD_I && ADDR_I == OFF_ACCESS_DATA;
  assign ur = RD_I && !cr && !dr;
  property p_rd_idle; !RD_I |=> RDATA_O == '0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_resv; cr |=> RDATA_O[31:16] == '0 && RDATA_O[5:2] == '0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits set");
  property p_busy; cw ##1 cr |=> RDATA_O[0]; endproperty
  a_busy: assert property (p_busy) else $error("busy not set");
  property p_fld;
    cw ##1 cr |=> RDATA_O[15:6] == $past(WDATA_I[15:6], 2) && RDATA_O[1] == $past(WDATA_I[1], 2);
  endproperty
  a_fld: assert property (p_fld) else $error("control fields lost");
  property p_dhi; dr |=> RDATA_O[31:16] == '0; endproperty
  a_dhi: assert property (p_dhi) else $error("data upper bits set");
  property p_unm; ur |=> RDATA_O == '0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_start; cw |-> ##[1:64] MDC_O; endproperty
  a_start: assert property (p_start) else $error("no management cycle");
  property p_rst; disable iff (1'b0) !RST_B_I |=> !MDC_O && !MDIO_OE_O && RDATA_O == '0; endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");
  cover property (cw ##1 cr);
  cover property ($rose(MDC_O));
  cover property (dr ##1 RDATA_O[15:0] != '0);
endmodule
bind iphy_access iphy_access_sva u_iphy_access_sva (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .MDC_O(MDC_O), .MDIO_OE_O(MDIO_OE_O));

// File: dv/iphy_phy_model.sv
// behavioural phy management register set
`timescale 1ns/10ps
module iphy_phy_model (
  input  wire logic mdc_i,
  input  wire logic mdio_i,
  output logic      mdio_o,
  output logic      mdio_oe_o
);
  logic [15:0] mem [0:1023];
  logic [63:0] sr;
  logic [15:0] rd;
  logic [5:0]  cnt = '0;
  logic        drv = 1'b0;
  initial mdio_o = 1'b1;
  assign mdio_oe_o = drv;
  always @(posedge mdc_i) begin
    sr = {sr[62:0], mdio_i};
    if (cnt == 6'd47 && sr[13:12] == 2'b10) begin
      rd = mem[sr[11:2]];
      drv = 1'b1;
    end
    if (cnt >= 6'd48 && drv) begin
      mdio_o <= rd[15];
      rd = {rd[14:0], 1'b0};
    end else
      mdio_o <= ~mdio_o;
    if (cnt == 6'd63 && sr[29:28] == 2'b01) mem[sr[27:18]] = sr[15:0];
    cnt = cnt + 6'd1;
  end
  // release the line after the last falling edge of a frame
  always @(negedge mdc_i) if (cnt == 6'd0) drv <= 1'b0;
endmodule

// File: dv/iphy_access_tb_top.sv
// testbench for the indirect phy access block
`timescale 1ns/10ps
module iphy_access_tb_top;
  import iphy_pkg::*;
  logic CLK_I = 0, RST_B_I = 0, WR_I = 0, RD_I = 0, m_o, m_oe, mdc, mdo, mdo_oe, rd_v = 0;
  logic [11:0] ADDR_I = '0;
  logic [31:0] WDATA_I = '0, RDATA_O, last_rd, dummy;
  logic [63:0] nq [$];
  int miscompares = 0, check_count = 0;
  wire mdio = mdo_oe ? mdo : (m_oe ? m_o : 1'b1);
  always #10 CLK_I = ~CLK_I;
  iphy_access #(.MDC_DIV(4)) u_iphy_access (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .MDC_O(mdc),
    .MDIO_O(mdo), .MDIO_OE_O(mdo_oe), .MDIO_I(mdio));
  iphy_phy_model u_iphy_phy_model (.mdc_i(mdc), .mdio_i(mdio), .mdio_o(m_o), .mdio_oe_o(m_oe));
  ////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, r, input logic [11:0] a, input logic [31:0] d, m, e);
    WR_I <= w;
    RD_I <= r;
    ADDR_I <= a;
    WDATA_I <= d;
    if (r) nq.push_back({m, e});
    @(posedge CLK_I);
  endtask
  task automatic cmp(input logic [31:0] e, g);
    check_count++;
    if (e !== g) begin
      miscompares++;
      $display("mismatch read data exp %h got %h", e, g);
    end
  endtask
  task automatic poll;
    int n;
    n = 0;
    do begin
      bus(0, 1, OFF_ACCESS_CTRL, 0, 0, 0);
      bus(0, 0, 0, 0, 0, 0);
      n++;
    end while (last_rd[0] !== 1'b0 && n < 300);
    if (n >= 300) miscompares++;
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge CLK_I) rd_v <= RD_I;
  always @(negedge CLK_I) if (rd_v) begin
    logic [63:0] nt;
    last_rd = RDATA_O;
    nt = nq.pop_front();
    if (nt[63:32] != '0) cmp(nt[31:0] & nt[63:32], RDATA_O & nt[63:32]);
  end
  initial begin
    #(20 * 20000);
    miscompares++;
    end_of_test;
  end
  initial begin
    logic [4:0] pa, ri;
    logic [15:0] d;
    dummy = $urandom(32'hf3da856c);
    repeat (10) @(posedge CLK_I);
    RST_B_I <= 1'b1;
    @(posedge CLK_I);
    bus(0, 1, OFF_ACCESS_CTRL, 0, '1, 0);
    bus(0, 1, OFF_ACCESS_DATA, 0, '1, 0);
    bus(0, 1, 12'h0_0ac, 0, '1, 0);
    repeat (4) begin
      pa = 5'($urandom);
      ri = 5'($urandom);
      d = 16'($urandom);
      bus(1, 0, OFF_ACCESS_DATA, {16'h0000, d}, 0, 0);
      bus(1, 0, OFF_ACCESS_CTRL, {~d, pa, ri, 6'h3f}, 0, 0);
      bus(0, 1, OFF_ACCESS_CTRL, 0, '1, {16'h0000, pa, ri, 6'h03});
      poll;
      bus(0, 1, OFF_ACCESS_DATA, 0, '1, {16'h0000, d});
      bus(1, 0, OFF_ACCESS_CTRL, {16'h0000, pa, ri, 6'h00}, 0, 0);
      poll;
      bus(0, 1, OFF_ACCESS_DATA, 0, '1, {16'h0000, d});
      bus(0, 1, OFF_ACCESS_CTRL, 0, '1, {16'h0000, pa, ri, 6'h00});
      bus(0, 0, 0, 0, 0, 0);
    end
    repeat (3) @(posedge CLK_I);
    end_of_test;
  end
endmodule
